/* hw/ccp_ctrl.sv */
`timescale 1ns/1ps
module ccp_ctrl
    import ccp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // straps and settings
    input wire logic spi_select_i,
    input wire logic general_call_enable_i,
    // shared control pins
    input wire logic bus_clock_or_select_pin_i,
    input wire logic addr_sclk_i,
    input wire logic sda_mosi_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic serial_out_shared_pin_o,
    output logic serial_out_shared_pin_oe_o,
    // register space
    output ccp_pkg::ccp_req_t req_o,
    input wire logic [7:0] reg_rdata_i
);
    import ccp_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_s;
    logic [SYNC_W-1:0] pins_d_reg;

    ccp_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({spi_select_i, sda_mosi_i, addr_sclk_i,
                  bus_clock_or_select_pin_i}),
        .sync_o(pins_s)
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pins_d_reg <= '1;
        else
            pins_d_reg <= pins_s;
    end

    logic spi_mode;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic ss_low;
    logic ss_fall;
    logic sclk_rise;
    logic sclk_fall;

    assign spi_mode = pins_s[PIN_SPI_SEL];
    assign scl_s = pins_s[PIN_CLK_SEL];
    assign sda_s = pins_s[PIN_DATA_IN];
    assign scl_rise = scl_s & ~pins_d_reg[PIN_CLK_SEL];
    assign scl_fall = ~scl_s & pins_d_reg[PIN_CLK_SEL];
    // both edges of data with clock held high mark framing
    assign i2c_start = scl_s & pins_d_reg[PIN_CLK_SEL]
        & ~sda_s & pins_d_reg[PIN_DATA_IN];
    assign i2c_stop = scl_s & pins_d_reg[PIN_CLK_SEL]
        & sda_s & ~pins_d_reg[PIN_DATA_IN];
    // SPI reuses the same pins in other roles
    assign ss_low = ~pins_s[PIN_CLK_SEL];
    assign ss_fall = ss_low & pins_d_reg[PIN_CLK_SEL];
    assign sclk_rise = pins_s[PIN_ADDR_SCLK]
        & ~pins_d_reg[PIN_ADDR_SCLK];
    assign sclk_fall = ~pins_s[PIN_ADDR_SCLK]
        & pins_d_reg[PIN_ADDR_SCLK];

    // ------------------------------------------------------------
    // address match
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] b,
                                      input logic strap,
                                      input logic gce);
        addr_hit = (b[7:1] == {I2C_PREFIX, strap})
            || (gce && (b[7:1] == GC_ADDR));
    endfunction

    // ------------------------------------------------------------
    // I2C slave
    // ------------------------------------------------------------
    ccp_i2c_st_t i_st_reg;
    logic [3:0] i_cnt_reg;
    logic [7:0] i_sh_reg;
    logic [7:0] i_tx_reg;
    logic [7:0] i_ptr_reg;
    logic i_rw_reg;
    logic i_ptr_ph_reg;
    logic i_mack_reg;
    logic i_load_reg;
    logic i_oe_reg;
    ccp_req_t i_req_reg;

    // the device only ever pulls data low; it never touches the clock
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            i_st_reg <= I_IDLE;
            i_cnt_reg <= '0;
            i_sh_reg <= ZERO_BYTE;
            i_tx_reg <= ZERO_BYTE;
            i_ptr_reg <= ZERO_BYTE;
            i_rw_reg <= 1'b0;
            i_ptr_ph_reg <= 1'b0;
            i_mack_reg <= 1'b0;
            i_oe_reg <= 1'b0;
        end
        else if (spi_mode)
        begin
            i_st_reg <= I_IDLE;
            i_oe_reg <= 1'b0;
        end
        else if (i2c_start)
        begin
            i_st_reg <= I_ADDR;
            i_cnt_reg <= '0;
            i_oe_reg <= 1'b0;
        end
        else if (i2c_stop)
        begin
            i_st_reg <= I_IDLE;
            i_oe_reg <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (i_st_reg)
                I_ADDR, I_WRX:
                begin
                    i_sh_reg <= {i_sh_reg[6:0], sda_s};
                    i_cnt_reg <= i_cnt_reg + 4'h1;
                end
                I_TX:
                    i_cnt_reg <= i_cnt_reg + 4'h1;
                I_RACK:
                begin
                    i_mack_reg <= ~sda_s;
                    if (!sda_s)
                        i_ptr_reg <= i_ptr_reg + ONE_BYTE;
                end
                default:
                    i_cnt_reg <= i_cnt_reg;
            endcase
        end
        else if (i_load_reg)
            i_tx_reg <= reg_rdata_i;
        else if (scl_fall)
        begin
            case (i_st_reg)
                I_ADDR:
                begin
                    if (i_cnt_reg == BYTE_BITS)
                    begin
                        i_cnt_reg <= '0;
                        i_rw_reg <= i_sh_reg[0];
                        i_ptr_ph_reg <= ~i_sh_reg[0];
                        if (addr_hit(i_sh_reg, pins_s[PIN_ADDR_SCLK],
                                     general_call_enable_i))
                        begin
                            i_st_reg <= I_WACK;
                            i_oe_reg <= 1'b1;
                        end
                        else
                            i_st_reg <= I_SKIP;
                    end
                end
                I_WRX:
                begin
                    if (i_cnt_reg == BYTE_BITS)
                    begin
                        i_cnt_reg <= '0;
                        i_st_reg <= I_WACK;
                        i_oe_reg <= 1'b1;
                        if (i_ptr_ph_reg)
                        begin
                            i_ptr_reg <= i_sh_reg;
                            i_ptr_ph_reg <= 1'b0;
                        end
                        else
                            i_ptr_reg <= i_ptr_reg + ONE_BYTE;
                    end
                end
                I_WACK:
                begin
                    if (i_rw_reg)
                    begin
                        i_st_reg <= I_TX;
                        i_oe_reg <= ~i_tx_reg[7];
                    end
                    else
                    begin
                        i_st_reg <= I_WRX;
                        i_oe_reg <= 1'b0;
                    end
                end
                I_TX:
                begin
                    if (i_cnt_reg == BYTE_BITS)
                    begin
                        i_cnt_reg <= '0;
                        i_st_reg <= I_RACK;
                        i_oe_reg <= 1'b0;
                    end
                    else
                    begin
                        i_tx_reg <= {i_tx_reg[6:0], 1'b0};
                        i_oe_reg <= ~i_tx_reg[6];
                    end
                end
                I_RACK:
                begin
                    if (i_mack_reg)
                    begin
                        i_st_reg <= I_TX;
                        i_oe_reg <= ~i_tx_reg[7];
                    end
                    else
                        i_st_reg <= I_SKIP;
                end
                default:
                    i_oe_reg <= 1'b0;
            endcase
        end
    end

    // read fetch on the ack clock, write only once a whole byte is in
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            i_req_reg <= '0;
            i_load_reg <= 1'b0;
        end
        else
        begin
            i_req_reg.wr <= 1'b0;
            i_req_reg.rd <= 1'b0;
            i_load_reg <= i_req_reg.rd;
            if (!spi_mode && scl_fall && i_st_reg == I_WRX
                && i_cnt_reg == BYTE_BITS && !i_ptr_ph_reg)
            begin
                i_req_reg.wr <= 1'b1;
                i_req_reg.addr <= i_ptr_reg;
                i_req_reg.data <= i_sh_reg;
            end
            else if (!spi_mode && scl_rise && i_st_reg == I_WACK
                     && i_rw_reg)
            begin
                i_req_reg.rd <= 1'b1;
                i_req_reg.addr <= i_ptr_reg;
            end
            else if (!spi_mode && scl_rise && i_st_reg == I_RACK
                     && !sda_s)
            begin
                i_req_reg.rd <= 1'b1;
                i_req_reg.addr <= i_ptr_reg + ONE_BYTE;
            end
        end
    end

    // ------------------------------------------------------------
    // SPI slave, mode 1: drive on rise, sample on fall
    // ------------------------------------------------------------
    ccp_spi_st_t s_st_reg;
    logic [3:0] s_cnt_reg;
    logic [7:0] s_sh_reg;
    logic [7:0] s_tx_reg;
    logic s_rw_reg;
    logic s_load_reg;
    logic s_oe_reg;
    logic s_out_reg;
    ccp_req_t s_req_reg;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_st_reg <= S_IDLE;
            s_cnt_reg <= '0;
            s_sh_reg <= ZERO_BYTE;
            s_tx_reg <= ZERO_BYTE;
            s_rw_reg <= 1'b0;
            s_oe_reg <= 1'b0;
            s_out_reg <= 1'b0;
        end
        else if (!spi_mode || !ss_low)
        begin
            s_st_reg <= S_IDLE;
            s_oe_reg <= 1'b0;
        end
        else if (ss_fall)
        begin
            s_st_reg <= S_CMD;
            s_cnt_reg <= '0;
            s_tx_reg <= ZERO_BYTE;
        end
        else if (s_load_reg)
            s_tx_reg <= reg_rdata_i;
        else if (sclk_rise && s_st_reg != S_IDLE)
        begin
            s_oe_reg <= 1'b1;
            s_out_reg <= s_tx_reg[7];
            s_tx_reg <= {s_tx_reg[6:0], 1'b0};
        end
        else if (sclk_fall && s_st_reg != S_IDLE)
        begin
            s_sh_reg <= {s_sh_reg[6:0], sda_s};
            s_cnt_reg <= s_cnt_reg + 4'h1;
            case (s_st_reg)
                S_CMD:
                begin
                    if (s_cnt_reg == CMD_LAST)
                    begin
                        s_st_reg <= S_DATA;
                        s_rw_reg <= sda_s;
                    end
                end
                S_DATA:
                begin
                    if (s_cnt_reg == FRAME_LAST)
                        s_st_reg <= S_DONE;
                end
                default:
                    s_cnt_reg <= s_cnt_reg;
            endcase
        end
    end

    // only the first command after select falls is acted on
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_req_reg <= '0;
            s_load_reg <= 1'b0;
        end
        else
        begin
            s_req_reg.wr <= 1'b0;
            s_req_reg.rd <= 1'b0;
            s_load_reg <= s_req_reg.rd;
            if (spi_mode && ss_low && sclk_fall && s_st_reg == S_CMD
                && s_cnt_reg == CMD_LAST)
            begin
                s_req_reg.addr <= {1'b0, s_sh_reg[6:0]};
                s_req_reg.rd <= sda_s;
            end
            else if (spi_mode && ss_low && sclk_fall
                     && s_st_reg == S_DATA && s_cnt_reg == FRAME_LAST
                     && !s_rw_reg)
            begin
                s_req_reg.wr <= 1'b1;
                s_req_reg.data <= {s_sh_reg[6:0], sda_s};
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_o = spi_mode ? s_req_reg : i_req_reg;
    assign sda_o = 1'b0;
    assign sda_oe_o = i_oe_reg;
    assign serial_out_shared_pin_o = s_out_reg;
    assign serial_out_shared_pin_oe_o = s_oe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_spi_quiet_sda: assert property (@(posedge clk_i)
        disable iff (rst_i) spi_mode |=> !sda_oe_o)
        else $error("sda driven in spi mode");
    a_start_to_addr: assert property (@(posedge clk_i)
        disable iff (rst_i) (!spi_mode && i2c_start) |=> (i_st_reg == I_ADDR))
        else $error("start did not open address phase");
    a_stop_to_idle: assert property (@(posedge clk_i)
        disable iff (rst_i) (!spi_mode && i2c_stop && !i2c_start)
        |=> (i_st_reg == I_IDLE) && !sda_oe_o) else $error("stop not idle");
    a_addr_ack: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!spi_mode && !i2c_start && !i2c_stop && !scl_rise && !i_load_reg
        && scl_fall && i_st_reg == I_ADDR && i_cnt_reg == BYTE_BITS)
        |=> (sda_oe_o == addr_hit($past(i_sh_reg),
        $past(pins_s[PIN_ADDR_SCLK]), $past(general_call_enable_i))))
        else $error("address ack wrong");
    a_wr_full_byte: assert property (@(posedge clk_i)
        disable iff (rst_i) (i_req_reg.wr && !spi_mode)
        |-> ($past(i_st_reg) == I_WRX) && ($past(i_cnt_reg) == BYTE_BITS))
        else $error("write before full byte");
    a_wr_one_pulse: assert property (@(posedge clk_i)
        disable iff (rst_i) req_o.wr |=> !req_o.wr)
        else $error("write strobe too long");
    a_miso_idle: assert property (@(posedge clk_i)
        disable iff (rst_i) !ss_low |=> !serial_out_shared_pin_oe_o)
        else $error("miso driven without select");
    a_spi_rd_load: assert property (@(posedge clk_i)
        disable iff (rst_i) (spi_mode && s_req_reg.rd) |=> s_load_reg ##1
        (!ss_low || s_tx_reg == $past(reg_rdata_i)))
        else $error("read data not loaded");
    a_spi_no_rd_wr: assert property (@(posedge clk_i)
        disable iff (rst_i) (spi_mode && s_req_reg.wr) |-> !s_rw_reg)
        else $error("write issued for read command");

endmodule

/* hw/ccp_pkg.sv */
package ccp_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int SYNC_W = 4;
    localparam int PIN_CLK_SEL = 0;
    localparam int PIN_ADDR_SCLK = 1;
    localparam int PIN_DATA_IN = 2;
    localparam int PIN_SPI_SEL = 3;
    localparam logic [5:0] I2C_PREFIX = 6'h0C;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CMD_LAST = 4'h7;
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } ccp_req_t;

    typedef enum logic [6:0] {
        I_IDLE = 7'h01,
        I_ADDR = 7'h02,
        I_WACK = 7'h04,
        I_WRX = 7'h08,
        I_TX = 7'h10,
        I_RACK = 7'h20,
        I_SKIP = 7'h40
    } ccp_i2c_st_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_CMD = 4'h2,
        S_DATA = 4'h4,
        S_DONE = 4'h8
    } ccp_spi_st_t;

endpackage

/* hw/ccp_sync.sv */
`timescale 1ns/1ps
module ccp_sync
    import ccp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins
    input wire logic [SYNC_W-1:0] async_i,
    output logic [SYNC_W-1:0] sync_o
);

    // ------------------------------------------------------------
    // two-flop synchroniser per pin
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++)
        begin : g_bit
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    meta_reg[g] <= 1'b1;
                    sync_reg[g] <= 1'b1;
                end
                else
                begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_reg;

endmodule

/* verification/ccp_host_model.sv */
`timescale 1ns/1ps
module ccp_host_model
(
    // clock
    input wire logic clk_i,
    // device pins seen
    input wire logic sda_i,
    input wire logic sda_oe_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    // pins driven toward the device
    output logic spi_select_o,
    output logic pin_clk_sel_o,
    output logic pin_addr_sclk_o,
    output logic pin_data_o
);
    // ------------------------------------------------------------
    // wires
    // ------------------------------------------------------------
    logic spi_mode = 1'b0;
    logic strap = 1'b0;
    logic scl = 1'b1;
    logic pull = 1'b0;
    logic ss_n = 1'b1;
    logic sclk = 1'b0;
    logic mosi = 1'b0;
    logic miso_last = 1'b0;
    logic sda_w;
    logic miso_w;

    // open drain: a released line floats high through the pull-up
    assign sda_w = (sda_oe_i ? sda_i : 1'b1) & ~pull;
    // undriven miso shows the inverse so a stale value never matches
    assign miso_w = miso_oe_i ? miso_i : ~miso_last;
    always @(posedge clk_i)
        if (miso_oe_i)
            miso_last <= miso_i;
    assign spi_select_o = spi_mode;
    assign pin_clk_sel_o = spi_mode ? ss_n : scl;
    assign pin_addr_sclk_o = spi_mode ? sclk : strap;
    assign pin_data_o = spi_mode ? mosi : sda_w;

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // short settle after each clock fall keeps data off the clock edge
    task automatic i2c_start();
        wt(4);
        pull = 1'b0;
        wt(16);
        scl = 1'b1;
        wt(16);
        pull = 1'b1;
        wt(16);
        scl = 1'b0;
    endtask

    task automatic i2c_stop();
        wt(4);
        pull = 1'b1;
        wt(16);
        scl = 1'b1;
        wt(16);
        pull = 1'b0;
        wt(16);
    endtask

    task automatic i2c_bit(input logic b, output logic r);
        wt(4);
        pull = ~b;
        wt(12);
        scl = 1'b1;
        wt(16);
        r = sda_w;
        scl = 1'b0;
    endtask

    // whole bytes only, so reserved bits go out as the caller gives them
    task automatic i2c_byte(input logic [7:0] d, input logic ackbit,
                            output logic [7:0] rd, output logic ack);
        for (int i = 7; i >= 0; i--)
            i2c_bit(d[i], rd[i]);
        i2c_bit(ackbit, ack);
    endtask

    task automatic spi_frame(input logic [15:0] tx, output logic [15:0] rx);
        ss_n = 1'b0;
        wt(16);
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b1;
            mosi = tx[i];
            wt(16);
            sclk = 1'b0;
            rx[i] = miso_w;
            wt(16);
        end
        ss_n = 1'b1;
        mosi = ~mosi;
        wt(16);
    endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import ccp_pkg::*;
    // ------------------------------------------------------------
    // wires
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic gce = 1'b0;
    logic spi_select;
    logic pin_cs;
    logic pin_as;
    logic pin_d;
    logic sda_o;
    logic sda_oe_o;
    logic miso_o;
    logic miso_oe_o;
    ccp_req_t req_o;
    logic [7:0] reg_rdata;
    logic [7:0] mem [256];
    logic [15:0] wq [$];
    int miscompares = 0;
    int total_checks = 0;

    initial
        forever #2.5 clk_i = ~clk_i;

    ccp_ctrl ccp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .spi_select_i(spi_select), .general_call_enable_i(gce),
        .bus_clock_or_select_pin_i(pin_cs), .addr_sclk_i(pin_as),
        .sda_mosi_i(pin_d), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .serial_out_shared_pin_o(miso_o),
        .serial_out_shared_pin_oe_o(miso_oe_o),
        .req_o(req_o), .reg_rdata_i(reg_rdata));

    ccp_host_model ccp_host_model_i (.clk_i(clk_i), .sda_i(sda_o),
        .sda_oe_i(sda_oe_o), .miso_i(miso_o), .miso_oe_i(miso_oe_o),
        .spi_select_o(spi_select), .pin_clk_sel_o(pin_cs),
        .pin_addr_sclk_o(pin_as), .pin_data_o(pin_d));

    // register space stand-in: address stays put, so data is ready in time
    initial
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h3C;
    assign reg_rdata = mem[req_o.addr];
    always @(posedge clk_i)
        if (req_o.wr === 1'b1)
        begin
            mem[req_o.addr] <= req_o.data;
            wq.push_back({req_o.addr, req_o.data});
        end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_i2c_write();
        logic [7:0] rd;
        logic ack;
        ccp_host_model_i.i2c_start();
        ccp_host_model_i.i2c_byte(8'h30, 1'b1, rd, ack);
        check(ack, 16'h0000);
        ccp_host_model_i.i2c_byte(8'h05, 1'b1, rd, ack);
        check(ack, 16'h0000);
        ccp_host_model_i.i2c_byte(8'hA7, 1'b1, rd, ack);
        check(ack, 16'h0000);
        ccp_host_model_i.i2c_byte(8'hB8, 1'b1, rd, ack);
        check(ack, 16'h0000);
        ccp_host_model_i.i2c_stop();
        check(16'(wq.size()), 16'h0002);
        check(wq[0], 16'h05A7);
        check(wq[1], 16'h06B8);
    endtask

    task automatic t_i2c_read();
        logic [7:0] rd;
        logic ack;
        ccp_host_model_i.i2c_start();
        ccp_host_model_i.i2c_byte(8'h30, 1'b1, rd, ack);
        ccp_host_model_i.i2c_byte(8'h10, 1'b1, rd, ack);
        ccp_host_model_i.i2c_start();
        ccp_host_model_i.i2c_byte(8'h31, 1'b1, rd, ack);
        check(ack, 16'h0000);
        ccp_host_model_i.i2c_byte(8'hFF, 1'b0, rd, ack);
        check(rd, 16'h002C);
        ccp_host_model_i.i2c_byte(8'hFF, 1'b1, rd, ack);
        check(rd, 16'h002D);
        ccp_host_model_i.i2c_stop();
        check(16'(wq.size()), 16'h0002);
    endtask

    // {expect nack, general call enable, address byte}
    task automatic t_i2c_address();
        logic [9:0] tab [4] = '{10'h230, 10'h032, 10'h200, 10'h100};
        logic [7:0] rd;
        logic ack;
        ccp_host_model_i.strap = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            gce = tab[k][8];
            ccp_host_model_i.i2c_start();
            ccp_host_model_i.i2c_byte(tab[k][7:0], 1'b1, rd, ack);
            check(ack, 16'(tab[k][9]));
            ccp_host_model_i.i2c_stop();
        end
        gce = 1'b0;
    endtask

    // limitation: only two addresses, 12 and 7F hex, are swept
    task automatic t_spi();
        logic [6:0] adr [2] = '{7'h12, 7'h7F};
        logic [7:0] dat [2] = '{8'h5C, 8'hE1};
        logic [15:0] rx;
        ccp_host_model_i.spi_mode = 1'b1;
        ccp_host_model_i.wt(8);
        for (int k = 0; k < 2; k++)
        begin
            ccp_host_model_i.spi_frame({adr[k], 1'b0, dat[k]}, rx);
            check(rx[15:8], 16'h0000);
            check(wq[2 + k], {1'b0, adr[k], dat[k]});
            ccp_host_model_i.spi_frame({adr[k], 1'b1, 8'h00}, rx);
            check(rx[7:0], 16'(dat[k]));
            check(16'(wq.size()), 16'(3 + k));
            check(miso_oe_o, 16'h0000);
            check(sda_oe_o, 16'h0000);
        end
    endtask

    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        t_i2c_write();
        t_i2c_read();
        t_i2c_address();
        t_spi();
        final_report();
    end

    // whole run is near 33 us of link traffic
    initial
    begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule
